// *** rtl/hsp_pkg.sv ***
// What this block does
// - link runs asynchronously from 9600 to 921600 bps, plus 1 Mbps.
// - each character is eight data bits, no parity, one stop bit.
// - flow control uses request-to-send and clear-to-send, both active low.
// - after request-to-send drops the receiver still takes four more characters.
// - with clear-to-send left open the wake handshake stays off until the next reset.
// - wake mode off: clear-to-send pulled down, wake pins disconnected inputs.
// - wake mode on: clear-to-send and wake input float, no pull resistor.
// - wake mode on: the wake output is driven push-pull.
// - call control going high during data transfer hangs up and drops the wireless link.
// - generated baud rate stays within one percent of each nominal rate.
// - during reset and until initialisation all serial and wake pins are undriven.
// - flow control is recommended both ways; without it data may be lost.
package hsp_pkg;
  // ****************************
  // register map
  // ****************************
  localparam logic [4:0] HSP_CTRL_OFS = 5'h00;
  localparam logic [4:0] HSP_BAUD_OFS = 5'h04;
  localparam logic [4:0] HSP_TXDATA_OFS = 5'h08;
  localparam logic [4:0] HSP_RXDATA_OFS = 5'h0c;
  localparam logic [4:0] HSP_STATUS_OFS = 5'h10;
  // control fields
  localparam int HSP_CTRL_ENABLE = 0;
  localparam int HSP_CTRL_WAKE_MODE = 1;
  localparam int HSP_CTRL_FOUR_WIRE = 2;
  localparam int HSP_CTRL_WAKE_OUT = 3;
  // status fields
  localparam int HSP_ST_RX_AVAIL = 0;
  localparam int HSP_ST_TX_BUSY = 1;
  localparam int HSP_ST_CTS = 2;
  localparam int HSP_ST_WAKE_IN = 3;
  localparam int HSP_ST_CALL = 4;
  localparam int HSP_ST_HANGUP = 5;
  localparam int HSP_ST_OVERRUN = 6;
  localparam int HSP_ST_FRAME_ERR = 7;
  localparam int HSP_ST_RX_COUNT = 8;
  localparam int HSP_RXDATA_VALID = 8;
  localparam logic [31:0] HSP_CTRL_RESET = 32'h0000_0000;
  // synchroniser reset per pin {call, wake in, cts, rxd}: call control idles low
  localparam logic [3:0] HSP_PIN_RESET = 4'h7;
  // ****************************
  // timing
  // ****************************
  localparam int HSP_CLK_HZ = 200_000_000;
  localparam int HSP_DEFAULT_BPS = 115200;
  localparam logic [15:0] HSP_BAUD_RESET = 16'((HSP_CLK_HZ + HSP_DEFAULT_BPS / 2)
    / HSP_DEFAULT_BPS);
  localparam int HSP_RTS_MARGIN = 4;
  localparam logic [1:0] HSP_RESP_OKAY = 2'h0;
  localparam logic [1:0] HSP_RESP_SLVERR = 2'h2;
  // ****************************
  // character engine states
  // ****************************
  typedef enum logic [1:0] {
    HSP_IDLE = 2'h0,
    HSP_START = 2'h1,
    HSP_DATA = 2'h3,
    HSP_STOP = 2'h2
  } hsp_state_type;
endpackage

// *** rtl/hsp_uart.sv ***
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
module hsp_uart
  import hsp_pkg::*;
#(
  parameter int RX_DEPTH = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rxd,
  input wire logic cts_n,
  input wire logic wake_in_n,
  input wire logic call_ctrl,
  input wire logic data_phase,
  output logic txd,
  output logic txd_oe,
  output logic rts_n,
  output logic rts_n_oe,
  output logic wake_out_n,
  output logic wake_out_oe,
  output logic cts_pulldown_en,
  output logic wake_in_input_en,
  output logic drop_link
);
  localparam int CW = $clog2(RX_DEPTH + 1);
  localparam int AW = $clog2(RX_DEPTH);

  // ****************************
  // pin synchronisers
  // ****************************
  logic [3:0] pin_raw;
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  assign pin_raw = {call_ctrl, wake_in_n, cts_n, rxd};
  // two flops per pin; the first is read only by the second
  for (genvar g = 0; g < 4; g++) begin : g_sync
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pin_meta[g] <= HSP_PIN_RESET[g]; // idle level, so no false edge after reset
        pin_sync[g] <= HSP_PIN_RESET[g];
      end else begin
        pin_meta[g] <= pin_raw[g];
        pin_sync[g] <= pin_meta[g];
      end
    end
  end
  logic rxd_s, cts_s, wake_in_s, call_s, call_prev;
  assign rxd_s = pin_sync[0];
  assign cts_s = pin_sync[1];
  assign wake_in_s = pin_sync[2];
  assign call_s = pin_sync[3];

  // ****************************
  // registers and pin modes
  // ****************************
  logic enable, wake_req, four_wire, wake_out_req;
  logic [15:0] baud_div;
  logic wake_en;
  logic hangup, overrun, frame_err;
  // wake mode is only live when enabled and not locked out by the open-cts setup
  assign wake_en = enable & wake_req & ~four_wire;
  // pins stay undriven inputs until software enables the port
  assign txd_oe = enable;
  assign rts_n_oe = enable;
  // pin type per wake mode
  assign cts_pulldown_en = enable & ~wake_en;
  assign wake_in_input_en = enable & wake_en;
  assign wake_out_oe = wake_en;
  assign wake_out_n = ~wake_out_req;

  // ****************************
  // axi4-lite slave
  // ****************************
  logic aw_held, w_held;
  logic [4:0] aw_ofs;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write, do_read, tx_push, rx_pop;
  logic tbuf_in_ready;
  logic [CW-1:0] rx_count;
  logic [7:0] rx_head;
  logic tx_busy;
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  // a data write waits while the transmit buffer is full
  assign do_write = aw_held & w_held & ~s_axi_bvalid
    & ((aw_ofs != HSP_TXDATA_OFS) | tbuf_in_ready);
  assign do_read = s_axi_arvalid & ~s_axi_rvalid;
  assign tx_push = do_write & (aw_ofs == HSP_TXDATA_OFS) & w_strb[0];
  assign rx_pop = do_read & (s_axi_araddr[4:0] == HSP_RXDATA_OFS)
    & (s_axi_araddr[31:5] == 27'h0) & (rx_count != '0);

  // address and data capture, response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_ofs <= 5'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= HSP_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_ofs <= (s_axi_awaddr[31:5] == 27'h0 && s_axi_awaddr[1:0] == 2'h0)
          ? s_axi_awaddr[4:0] : 5'h1f;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_ofs == HSP_CTRL_OFS || aw_ofs == HSP_BAUD_OFS || aw_ofs == HSP_TXDATA_OFS
            || aw_ofs == HSP_STATUS_OFS) begin
          s_axi_bresp <= HSP_RESP_OKAY;
        end else begin
          s_axi_bresp <= HSP_RESP_SLVERR;
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control and baud registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable <= HSP_CTRL_RESET[HSP_CTRL_ENABLE];
      wake_req <= HSP_CTRL_RESET[HSP_CTRL_WAKE_MODE];
      four_wire <= HSP_CTRL_RESET[HSP_CTRL_FOUR_WIRE];
      wake_out_req <= HSP_CTRL_RESET[HSP_CTRL_WAKE_OUT];
      baud_div <= HSP_BAUD_RESET;
    end else if (do_write && w_strb[0] && aw_ofs == HSP_CTRL_OFS) begin
      enable <= w_data[HSP_CTRL_ENABLE];
      wake_req <= w_data[HSP_CTRL_WAKE_MODE];
      four_wire <= four_wire | w_data[HSP_CTRL_FOUR_WIRE];
      wake_out_req <= w_data[HSP_CTRL_WAKE_OUT];
    end else if (do_write && aw_ofs == HSP_BAUD_OFS && w_strb[1:0] == 2'h3) begin
      // divisor of two or more keeps the mid-bit sample meaningful
      baud_div <= (w_data[15:0] < 16'h0002) ? 16'h0002 : w_data[15:0];
    end
  end

  // read data path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= HSP_RESP_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= HSP_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      if (s_axi_araddr[31:5] != 27'h0 || s_axi_araddr[1:0] != 2'h0) begin
        s_axi_rresp <= HSP_RESP_SLVERR;
      end else if (s_axi_araddr[4:0] == HSP_CTRL_OFS) begin
        s_axi_rdata <= {28'h0, wake_out_req, four_wire, wake_req, enable};
      end else if (s_axi_araddr[4:0] == HSP_BAUD_OFS) begin
        s_axi_rdata <= {16'h0, baud_div};
      end else if (s_axi_araddr[4:0] == HSP_RXDATA_OFS) begin
        s_axi_rdata <= {23'h0, rx_count != '0, (rx_count != '0) ? rx_head : 8'h00};
      end else if (s_axi_araddr[4:0] == HSP_STATUS_OFS) begin
        s_axi_rdata <= {16'h0, 8'(rx_count), frame_err, overrun, hangup, call_s,
          wake_in_s, cts_s, tx_busy, rx_count != '0};
      end else if (s_axi_araddr[4:0] != HSP_TXDATA_OFS) begin
        s_axi_rresp <= HSP_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************
  // two-entry transmit buffer
  // ****************************
  logic [7:0] tbuf [2];
  logic [1:0] tbuf_count;
  logic tbuf_wr, tbuf_rd;
  logic tbuf_out_valid, tbuf_out_ready;
  assign tbuf_in_ready = (tbuf_count != 2'h2);
  assign tbuf_out_valid = (tbuf_count != 2'h0);
  assign tbuf_wr = tx_push & tbuf_in_ready;
  assign tbuf_rd = tbuf_out_valid & tbuf_out_ready;
  // shift register style: entry 0 is always the oldest
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tbuf_count <= 2'h0;
      tbuf[0] <= 8'h00;
      tbuf[1] <= 8'h00;
    end else begin
      tbuf_count <= tbuf_count + 2'(tbuf_wr) - 2'(tbuf_rd);
      if (tbuf_rd) begin
        tbuf[0] <= (tbuf_wr && tbuf_count == 2'h1) ? w_data[7:0] : tbuf[1];
      end else if (tbuf_wr && tbuf_count == 2'h0) begin
        tbuf[0] <= w_data[7:0];
      end
      if (tbuf_wr && (tbuf_count - 2'(tbuf_rd)) == 2'h1) begin
        tbuf[1] <= w_data[7:0];
      end
    end
  end

  // ****************************
  // transmitter
  // ****************************
  hsp_state_type tx_state;
  logic [15:0] tx_cnt;
  logic [2:0] tx_bit;
  logic [7:0] tx_shift;
  logic tx_tick;
  assign tx_tick = (tx_cnt == baud_div - 16'h0001);
  // a new character starts only while clear-to-send is low
  assign tbuf_out_ready = (tx_state == HSP_IDLE) & enable & ~cts_s;
  assign tx_busy = (tx_state != HSP_IDLE) | tbuf_out_valid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_state <= HSP_IDLE;
      tx_cnt <= 16'h0000;
      tx_bit <= 3'h0;
      tx_shift <= 8'h00;
      txd <= 1'b1;
    end else begin
      tx_cnt <= (tx_state == HSP_IDLE || tx_tick) ? 16'h0000 : tx_cnt + 16'h0001;
      case (tx_state)
        HSP_IDLE: begin
          txd <= 1'b1;
          if (tbuf_rd) begin
            tx_shift <= tbuf[0];
            txd <= 1'b0;
            tx_state <= HSP_START;
          end
        end
        HSP_START: begin
          if (tx_tick) begin
            txd <= tx_shift[0];
            tx_bit <= 3'h0;
            tx_state <= HSP_DATA;
          end
        end
        HSP_DATA: begin
          if (tx_tick) begin
            if (tx_bit == 3'h7) begin
              txd <= 1'b1;
              tx_state <= HSP_STOP;
            end else begin
              txd <= tx_shift[tx_bit + 3'h1];
              tx_bit <= tx_bit + 3'h1;
            end
          end
        end
        HSP_STOP: begin
          if (tx_tick) begin
            tx_state <= HSP_IDLE;
          end
        end
        default: tx_state <= HSP_IDLE;
      endcase
    end
  end

  // ****************************
  // receiver
  // ****************************
  hsp_state_type rx_state;
  logic [15:0] rx_cnt;
  logic [2:0] rx_bit;
  logic [7:0] rx_shift;
  logic rx_tick, rx_done;
  assign rx_tick = (rx_cnt == ((rx_state == HSP_START) ? (baud_div >> 1)
    : baud_div - 16'h0001));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_state <= HSP_IDLE;
      rx_cnt <= 16'h0000;
      rx_bit <= 3'h0;
      rx_shift <= 8'h00;
      rx_done <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      rx_cnt <= (rx_state == HSP_IDLE || rx_tick) ? 16'h0000 : rx_cnt + 16'h0001;
      case (rx_state)
        HSP_IDLE: begin
          if (enable && !rxd_s) begin
            rx_state <= HSP_START;
          end
        end
        HSP_START: begin
          // mid start bit: a glitch returns to idle
          if (rx_tick) begin
            rx_bit <= 3'h0;
            rx_state <= rxd_s ? HSP_IDLE : HSP_DATA;
          end
        end
        HSP_DATA: begin
          if (rx_tick) begin
            rx_shift <= {rxd_s, rx_shift[7:1]};
            rx_bit <= rx_bit + 3'h1;
            if (rx_bit == 3'h7) begin
              rx_state <= HSP_STOP;
            end
          end
        end
        HSP_STOP: begin
          if (rx_tick) begin
            rx_done <= 1'b1;
            rx_state <= HSP_IDLE;
          end
        end
        default: rx_state <= HSP_IDLE;
      endcase
    end
  end

  // ****************************
  // receive fifo and request-to-send
  // ****************************
  logic [7:0] rx_mem [RX_DEPTH];
  logic [AW-1:0] rx_wp, rx_rp;
  logic rx_push;
  assign rx_push = rx_done & (rx_count != CW'(RX_DEPTH));
  assign rx_head = rx_mem[rx_rp];
  always_ff @(posedge aclk) begin
    if (rx_push) begin
      rx_mem[rx_wp] <= rx_shift;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_wp <= '0;
      rx_rp <= '0;
      rx_count <= '0;
    end else begin
      rx_wp <= rx_push ? AW'((32'(rx_wp) + 1) % RX_DEPTH) : rx_wp;
      rx_rp <= rx_pop ? AW'((32'(rx_rp) + 1) % RX_DEPTH) : rx_rp;
      rx_count <= rx_count + CW'(rx_push) - CW'(rx_pop);
    end
  end
  // deassert while room for no more than the margin remains
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rts_n <= 1'b1;
    end else begin
      rts_n <= ~enable | (rx_count >= CW'(RX_DEPTH - HSP_RTS_MARGIN));
    end
  end

  // ****************************
  // sticky status and call control
  // ****************************
  logic clr_status;
  assign clr_status = do_write & w_strb[0] & (aw_ofs == HSP_STATUS_OFS);
  // set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      call_prev <= 1'b0;
      drop_link <= 1'b0;
      hangup <= 1'b0;
      overrun <= 1'b0;
      frame_err <= 1'b0;
    end else begin
      call_prev <= call_s;
      drop_link <= enable & data_phase & call_s & ~call_prev;
      hangup <= (enable & data_phase & call_s & ~call_prev)
        | (hangup & ~(clr_status & w_data[HSP_ST_HANGUP]));
      overrun <= (rx_done & ~rx_push) | (overrun & ~(clr_status & w_data[HSP_ST_OVERRUN]));
      frame_err <= (rx_state == HSP_STOP & rx_tick & ~rxd_s)
        | (frame_err & ~(clr_status & w_data[HSP_ST_FRAME_ERR]));
    end
  end

  // ****************************
  // checks
  // ****************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_fill;
    enable && rx_count >= CW'(RX_DEPTH - HSP_RTS_MARGIN);
  endsequence
  sequence s_start;
    tx_state == HSP_IDLE ##1 tx_state == HSP_START;
  endsequence
  rts_drop_a: assert property (s_fill |=> rts_n)
    else $error("rts not dropped at fill level");
  cts_hold_a: assert property (tx_state == HSP_IDLE && cts_s |=> tx_state == HSP_IDLE)
    else $error("character started while cts high");
  start_low_a: assert property (s_start |-> !txd)
    else $error("start bit not low");
  idle_high_a: assert property (tx_state == HSP_IDLE && $past(tx_state) == HSP_IDLE |-> txd)
    else $error("idle line not high");
  stop_after_eight_a: assert property (tx_state == HSP_DATA && tx_tick && tx_bit == 3'h7
    |=> tx_state == HSP_STOP && txd)
    else $error("stop bit not after eighth data bit");
  bit_time_a: assert property (tx_state != HSP_IDLE |-> tx_cnt < baud_div)
    else $error("bit counter beyond divisor");
  four_wire_a: assert property (four_wire |-> !wake_en && !wake_out_oe)
    else $error("wake mode active in four-wire setup");
  wake_off_pins_a: assert property (enable && !wake_en
    |-> cts_pulldown_en && !wake_in_input_en && !wake_out_oe)
    else $error("pin types wrong with wake mode off");
  wake_on_pins_a: assert property (wake_en
    |-> wake_out_oe && wake_in_input_en && !cts_pulldown_en)
    else $error("pin types wrong with wake mode on");
  hang_up_a: assert property (enable && data_phase && $rose(call_s) |=> drop_link ##1 !drop_link)
    else $error("call control did not drop the link");
  undriven_a: assert property (!enable |-> !txd_oe && !rts_n_oe && !wake_out_oe
    && !cts_pulldown_en)
    else $error("pin driven before initialisation");
endmodule // hsp_uart
`default_nettype wire

// *** bench/hsp_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****************************
// host end of the serial link
// ****************************
module hsp_host_model #(
  parameter int BIT_CLKS = 16
) (
  input wire logic aclk,
  input wire logic txd,
  input wire logic rts_n,
  output logic rxd
);
  int late = 0;

  // the line rests high between characters
  initial rxd = 1'b1;

  // send one character; at most four more once request-to-send has dropped
  task automatic send(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    if (rts_n === 1'b1) late++;
    else late = 0;
    if (late > 4) return;
    for (int i = 0; i < 10; i++) begin
      @(posedge aclk);
      rxd <= frame[i];
      repeat (BIT_CLKS - 1) @(posedge aclk);
    end
  endtask

  // take one character off txd, sampling in mid-bit
  task automatic recv(output logic [7:0] b, output logic stop_ok);
    do @(posedge aclk); while (txd !== 1'b0);
    repeat (BIT_CLKS / 2) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge aclk);
      b[i] = txd;
    end
    repeat (BIT_CLKS) @(posedge aclk);
    stop_ok = (txd === 1'b1);
  endtask
endmodule // hsp_host_model
`default_nettype wire

// *** bench/host_serial_port_flow_wake_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module host_serial_port_flow_wake_tb
  import hsp_pkg::*;
;
  localparam int BIT_CLKS = 16;
  typedef struct {logic wr; logic [31:0] addr; logic [31:0] data; logic [1:0] resp;} hsp_row_type;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic rxd, cts_n, wake_in_n, call_ctrl, data_phase, txd, txd_oe, rts_n, rts_n_oe;
  logic wake_out_n, wake_out_oe, cts_pulldown_en, wake_in_input_en, drop_link;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  // register cases: access, address, data written or expected, response
  hsp_row_type rows [10] = '{
    '{1'b0, 32'h0, 32'h0, HSP_RESP_OKAY}, '{1'b0, 32'h4, 32'(HSP_BAUD_RESET), HSP_RESP_OKAY},
    '{1'b1, 32'h4, 32'h1, HSP_RESP_OKAY}, '{1'b0, 32'h4, 32'h2, HSP_RESP_OKAY},
    '{1'b1, 32'h4, 32'h10, HSP_RESP_OKAY}, '{1'b0, 32'h4, 32'h10, HSP_RESP_OKAY},
    '{1'b1, 32'hc, 32'h5, HSP_RESP_SLVERR}, '{1'b0, 32'h8, 32'h0, HSP_RESP_OKAY},
    '{1'b0, 32'h14, 32'h0, HSP_RESP_SLVERR}, '{1'b0, 32'h2, 32'h0, HSP_RESP_SLVERR}};

  // ****************************
  // clock, design and host
  // ****************************
  always #2.5 aclk = ~aclk;

  hsp_uart #(.RX_DEPTH(16)) u_hsp_uart (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rxd(rxd), .cts_n(cts_n),
    .wake_in_n(wake_in_n), .call_ctrl(call_ctrl), .data_phase(data_phase), .txd(txd),
    .txd_oe(txd_oe), .rts_n(rts_n), .rts_n_oe(rts_n_oe), .wake_out_n(wake_out_n),
    .wake_out_oe(wake_out_oe), .cts_pulldown_en(cts_pulldown_en),
    .wake_in_input_en(wake_in_input_en), .drop_link(drop_link));

  hsp_host_model #(.BIT_CLKS(BIT_CLKS)) u_hsp_host_model (.aclk(aclk), .txd(txd),
    .rts_n(rts_n), .rxd(rxd));

  // ****************************
  // checking and bus tasks
  // ****************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // counts drop_link pulses over ten cycles
  task automatic pulses(output int n);
    n = 0;
    repeat (10) begin
      @(posedge aclk);
      if (drop_link === 1'b1) n++;
    end
  endtask

  // cuts a hang short
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("wrong value at %0t: run took too long", $time);
      tally_and_finish();
    end
  end

  // ****************************
  // main sequence
  // ****************************
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] b;
    logic ok;
    int n;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    {cts_n, wake_in_n, call_ctrl, data_phase} = 4'h4;
    repeat (6) @(posedge aclk);
    check({txd_oe, rts_n_oe, wake_out_oe, cts_pulldown_en, wake_in_input_en}, 32'h0, "reset pins");
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) axi_write(rows[i].addr, rows[i].data, r);
      else axi_read(rows[i].addr, d, r);
      check(r, rows[i].resp, "row response");
      if (!rows[i].wr && rows[i].resp == HSP_RESP_OKAY) check(d, rows[i].data, "row data");
    end
    axi_write(32'h0, 32'h1, r);
    @(posedge aclk);
    check({txd_oe, rts_n_oe, cts_pulldown_en, wake_in_input_en, wake_out_oe}, 32'h1c, "on");
    fork
      axi_write(32'h8, 32'ha5, r);
      u_hsp_host_model.recv(b, ok);
    join
    check({ok, b}, 32'h1a5, "tx char");
    fork
      begin
        axi_write(32'h8, 32'h5a, r);
        axi_write(32'h8, 32'hc3, r);
      end
      begin
        u_hsp_host_model.recv(b, ok);
        check({ok, b}, 32'h15a, "first of two");
        u_hsp_host_model.recv(b, ok);
        check({ok, b}, 32'h1c3, "second of two");
      end
    join
    cts_n <= 1'b1;
    repeat (4) @(posedge aclk);
    axi_write(32'h8, 32'h81, r);
    n = 0;
    repeat (5 * BIT_CLKS) begin
      @(posedge aclk);
      if (txd !== 1'b1) n++;
    end
    check(n, 0, "tx held while not clear");
    cts_n <= 1'b0;
    u_hsp_host_model.recv(b, ok);
    check({ok, b}, 32'h181, "tx after clear");
    u_hsp_host_model.send(8'h3c);
    repeat (4) @(posedge aclk);
    axi_read(32'hc, d, r);
    check(d, 32'h13c, "rx char");
    for (int i = 0; i < 16; i++) begin
      u_hsp_host_model.send(8'(8'h40 + i));
      repeat (4) @(posedge aclk);
      if (i == 10 || i == 11) check(rts_n, 32'(i == 11), "rts level");
    end
    axi_read(32'h10, d, r);
    check({d[15:8], d[6], d[0]}, 32'h41, "four taken after rts");
    for (int i = 0; i < 16; i++) begin
      axi_read(32'hc, d, r);
      check(d, 32'h140 + 32'(i), "drained char");
    end
    @(posedge aclk);
    check(rts_n, 32'h0, "rts after drain");
    axi_read(32'hc, d, r);
    check(d, 32'h0, "empty rx read");
    call_ctrl <= 1'b1;
    pulses(n);
    check(n, 0, "no hang-up outside data phase");
    call_ctrl <= 1'b0;
    data_phase <= 1'b1;
    repeat (4) @(posedge aclk);
    call_ctrl <= 1'b1;
    pulses(n);
    check(n, 1, "hang-up pulse");
    axi_read(32'h10, d, r);
    check(d[5], 32'h1, "hang-up seen");
    axi_write(32'h10, 32'h20, r);
    axi_read(32'h10, d, r);
    check(d[5], 32'h0, "hang-up cleared");
    axi_write(32'h0, 32'hb, r);
    @(posedge aclk);
    check({wake_out_oe, wake_out_n, cts_pulldown_en, wake_in_input_en}, 32'h9, "wake");
    wake_in_n <= 1'b0;
    repeat (4) @(posedge aclk);
    axi_read(32'h10, d, r);
    check(d[3], 32'h0, "wake input level");
    axi_write(32'h0, 32'h7, r);
    @(posedge aclk);
    check({wake_out_oe, cts_pulldown_en, wake_in_input_en}, 32'h2, "four wire");
    axi_write(32'h0, 32'h3, r);
    @(posedge aclk);
    check({wake_out_oe, cts_pulldown_en, wake_in_input_en}, 32'h2, "four wire kept");
    // a divisor write without both low lanes leaves the divisor alone
    s_axi_wstrb <= 4'h1;
    axi_write(32'h4, 32'h20, r);
    s_axi_wstrb <= 4'hf;
    axi_read(32'h4, d, r);
    check(d, 32'h10, "baud needs both lanes");
    // a reset in mid-run parks the pins and lifts the four-wire lock
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    check({txd, rts_n, drop_link}, 32'h6, "lines in reset");
    check({txd_oe, rts_n_oe, wake_out_oe}, 32'h0, "drivers in reset");
    aresetn <= 1'b1;
    axi_read(32'h0, d, r);
    check(d, 32'h0, "ctrl after reset");
    axi_write(32'h0, 32'h3, r);
    @(posedge aclk);
    check({wake_out_oe, wake_in_input_en}, 32'h3, "wake after reset");
    tally_and_finish();
  end
endmodule // host_serial_port_flow_wake_tb
`default_nettype wire
